// ---- hdl/oksac_defines.svh ----
`ifndef OKSAC_DEFINES_SVH
`define OKSAC_DEFINES_SVH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define OKSAC_IDX_PEAK  8'h1b
`define OKSAC_IDX_AVG   8'h1c
`define OKSAC_IDX_FIX   8'h1d
`define OKSAC_IDX_CTL   8'h1e
`define OKSAC_IDX_CORH  8'h1f
`define OKSAC_IDX_CORL  8'h20
`define OKSAC_IDX_FEIH  8'h21
`define OKSAC_IDX_FEIL  8'h22
`define OKSAC_IDX_SSC   8'h23
`define OKSAC_IDX_SSV   8'h24
`define OKSAC_IDX_ISTAT 8'h40
`define OKSAC_IDX_IMASK 8'h41

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OKSAC_CTL_FEI_DONE  6
`define OKSAC_CTL_FEI_TRIG  5
`define OKSAC_CTL_COR_DONE  4
`define OKSAC_CTL_AUTOCLR   3
`define OKSAC_CTL_RX_ENTRY  2
`define OKSAC_CTL_COR_CLR   1
`define OKSAC_CTL_COR_TRIG  0
`define OKSAC_SSC_DONE      1
`define OKSAC_SSC_TRIG      0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OKSAC_RST_SEL    2'h1
`define OKSAC_RST_AVG    2'h2
`define OKSAC_RST_FIX    8'h06
`define OKSAC_RST_SSV    16'h00ff
`define OKSAC_RST_ZERO16 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define OKSAC_CLK_NS     5
`define OKSAC_FEI_NS     4000
`define OKSAC_COR_NS     8000
`define OKSAC_SS_NS      2000
`define OKSAC_FEI_CYC    ((`OKSAC_FEI_NS + `OKSAC_CLK_NS - 1) / `OKSAC_CLK_NS)
`define OKSAC_COR_CYC    ((`OKSAC_COR_NS + `OKSAC_CLK_NS - 1) / `OKSAC_CLK_NS)
`define OKSAC_SS_CYC     ((`OKSAC_SS_NS + `OKSAC_CLK_NS - 1) / `OKSAC_CLK_NS)

`endif

// ---- hdl/oksac_pkg.sv ----
package oksac_pkg;

    typedef enum logic [1:0] {
        OKSAC_THR_FIXED = 2'h0,
        OKSAC_THR_PEAK  = 2'h1,
        OKSAC_THR_AVG   = 2'h2,
        OKSAC_THR_RSVD  = 2'h3
    } oksac_thr_e;

    typedef enum logic {
        OKSAC_IDLE,
        OKSAC_RUN
    } oksac_meas_e;

    typedef struct packed {
        oksac_thr_e thr_sel;
        logic [2:0] step;
        logic [2:0] period;
        logic [1:0] filt;
        logic [7:0] fixed;
    } oksac_slicer_cfg_s;

endpackage

// ---- hdl/oksac_meas.sv ----
`include "oksac_defines.svh"

module oksac_meas
    import oksac_pkg::*;
#(
    parameter logic        DONE_RST = 1'b1,
    parameter logic [15:0] RES_RST  = 16'h0000,
    parameter logic [11:0] RUN_CYC  = 12'h001
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Trigger and sample
    input  wire logic        start,
    input  wire logic [15:0] sample,
    // Result
    output logic             done_ff,
    output logic             finish_ff,
    output logic [15:0]      result_ff
);

    oksac_meas_e state_ff;
    logic [11:0] cnt_ff;
    wire         last = (state_ff == OKSAC_RUN) && (cnt_ff == 12'h000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= OKSAC_IDLE;
            cnt_ff    <= 12'h000;
            done_ff   <= DONE_RST;
            finish_ff <= 1'b0;
            result_ff <= RES_RST;
        end else begin
            finish_ff <= 1'b0;
            case (state_ff)
                OKSAC_IDLE: begin
                    cnt_ff <= RUN_CYC - 12'h001;
                end
                OKSAC_RUN: begin
                    cnt_ff <= cnt_ff - 12'h001;
                end
                default: begin
                    cnt_ff <= 12'h000;
                end
            endcase
            // A new trigger restarts a running measurement
            if (start) begin
                state_ff <= OKSAC_RUN;
                cnt_ff   <= RUN_CYC - 12'h001;
                done_ff  <= 1'b0;
            end else if (last) begin
                state_ff  <= OKSAC_IDLE;
                done_ff   <= 1'b1;
                finish_ff <= 1'b1;
                result_ff <= sample;
            end
        end
    end

endmodule

// ---- hdl/oksac_top.sv ----
// How it works
// - Select field picks fixed, peak or average
// - Peak decay step 0.5 to 6 dB
// - Decay period per chips or per sub-chip
// - Average filter cutoff follows coefficient field
// - Fixed mode compares to programmed dB level
// - Error trigger starts measurement, done flag follows
// - Correction done flag, reset value one
// - Autoclear zeroes correction before automatic phase
// - Correction by trigger or on receive entry
// - Clear bit zeroes correction in receive mode
// - Correction trigger launches cycle only while receive-entry bit is clear, reads zero
// - Sixteen-bit signed correction over two bytes
// - Sixteen-bit signed frequency error over two bytes
// - Strength trigger starts measurement, reads zero
// - Strength done flag, reset value one
// - Strength result in half-dB, reset 0xff
//
// The AXI4-Lite register port is this design's own decision.
`include "oksac_defines.svh"

module oksac_top
    import oksac_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Demodulator datapath
    input  wire logic        rx_mode,
    input  wire logic [7:0]  strength_level,
    input  wire logic        subchip_tick,
    input  wire logic [15:0] freq_error_sample,
    input  wire logic [15:0] correction_sample,
    input  wire logic [7:0]  signal_strength_sample,
    // Results
    output logic             slicer_data_ff,
    output logic [15:0]      correction_value_ff,
    output logic             irq_ff
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (hit(a, `OKSAC_IDX_PEAK) | hit(a, `OKSAC_IDX_AVG) | hit(a, `OKSAC_IDX_FIX)
              | hit(a, `OKSAC_IDX_CTL) | hit(a, `OKSAC_IDX_CORH) | hit(a, `OKSAC_IDX_CORL)
              | hit(a, `OKSAC_IDX_FEIH) | hit(a, `OKSAC_IDX_FEIL) | hit(a, `OKSAC_IDX_SSC)
              | hit(a, `OKSAC_IDX_SSV) | hit(a, `OKSAC_IDX_ISTAT) | hit(a, `OKSAC_IDX_IMASK));
    endfunction

    // Step in half-dB units
    function automatic logic [8:0] step_half(input logic [2:0] code);
        case (code)
            3'h0:    return 9'h001;
            3'h1:    return 9'h002;
            3'h2:    return 9'h003;
            3'h3:    return 9'h004;
            3'h4:    return 9'h006;
            3'h5:    return 9'h008;
            3'h6:    return 9'h00a;
            default: return 9'h00c;
        endcase
    endfunction

    // Sub-chip ticks between decrements, minus one (16 ticks per chip)
    function automatic logic [7:0] decay_len(input logic [2:0] code);
        case (code)
            3'h0:    return 8'h0f;
            3'h1:    return 8'h1f;
            3'h2:    return 8'h3f;
            3'h3:    return 8'h7f;
            3'h4:    return 8'h07;
            3'h5:    return 8'h03;
            3'h6:    return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    oksac_slicer_cfg_s cfg_ff;
    logic              autoclr_ff;
    logic              rx_entry_on_ff;
    logic [2:0]        istat_ff;
    logic [2:0]        imask_ff;
    logic [11:0]       aw_addr_ff;
    logic              aw_full_ff;
    logic [7:0]        w_data_ff;
    logic              w_lane_ff;
    logic              w_full_ff;
    logic              rx_mode_dly_ff;
    logic [8:0]        thr_ff;
    logic signed [16:0] avg_ff;
    logic [7:0]        dec_cnt_ff;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    wire aw_take     = s_axi_awvalid & s_axi_awready;
    wire w_take      = s_axi_wvalid & s_axi_wready;
    wire do_wr       = aw_full_ff & w_full_ff & ~s_axi_bvalid;
    wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_wr;
    wire nxt_w_full  = (w_full_ff | w_take) & ~do_wr;
    wire wr_ok       = do_wr & w_lane_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_ff    <= 12'h000;
            aw_full_ff    <= 1'b0;
            w_data_ff     <= 8'h00;
            w_lane_ff     <= 1'b0;
            w_full_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_ff <= s_axi_wdata[7:0];
                w_lane_ff <= s_axi_wstrb[0];
            end
            aw_full_ff    <= nxt_aw_full;
            w_full_ff     <= nxt_w_full;
            s_axi_awready <= ~nxt_aw_full;
            s_axi_wready  <= ~nxt_w_full;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_ff) ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Write strobes per register, low byte lane only
    wire wr_peak  = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_PEAK);
    wire wr_avg   = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_AVG);
    wire wr_fix   = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_FIX);
    wire wr_ctl   = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_CTL);
    wire wr_ssc   = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_SSC);
    wire wr_istat = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_ISTAT);
    wire wr_imask = wr_ok & hit(aw_addr_ff, `OKSAC_IDX_IMASK);

    // Trigger bits are never stored, only pulsed
    wire fei_trig = wr_ctl & w_data_ff[`OKSAC_CTL_FEI_TRIG];
    wire cor_trig = wr_ctl & w_data_ff[`OKSAC_CTL_COR_TRIG];
    wire cor_clr  = wr_ctl & w_data_ff[`OKSAC_CTL_COR_CLR] & rx_mode;
    wire ss_trig  = wr_ssc & w_data_ff[`OKSAC_SSC_TRIG];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff         <= '{thr_sel: oksac_thr_e'(`OKSAC_RST_SEL), step: 3'h0, period: 3'h0,
                                filt: `OKSAC_RST_AVG, fixed: `OKSAC_RST_FIX};
            autoclr_ff     <= 1'b0;
            rx_entry_on_ff <= 1'b0;
            imask_ff       <= 3'h0;
        end else begin
            if (wr_peak) begin
                cfg_ff.thr_sel <= oksac_thr_e'(w_data_ff[7:6]);
                cfg_ff.step    <= w_data_ff[5:3];
                cfg_ff.period  <= w_data_ff[2:0];
            end
            if (wr_avg) begin
                cfg_ff.filt <= w_data_ff[7:6];
            end
            if (wr_fix) begin
                cfg_ff.fixed <= w_data_ff;
            end
            if (wr_ctl) begin
                autoclr_ff     <= w_data_ff[`OKSAC_CTL_AUTOCLR];
                rx_entry_on_ff <= w_data_ff[`OKSAC_CTL_RX_ENTRY];
            end
            if (wr_imask) begin
                imask_ff <= w_data_ff[2:0];
            end
        end
    end

    // ----------------------------------------
    // Measurement engines
    // ----------------------------------------
    wire        rx_entry = rx_mode & ~rx_mode_dly_ff;
    wire        cor_start = (cor_trig & ~rx_entry_on_ff) | (rx_entry & rx_entry_on_ff);
    wire        cor_zero = (cor_start & rx_entry_on_ff & autoclr_ff) | cor_clr;
    wire        fei_done;
    wire        fei_fin;
    wire [15:0] fei_val;
    wire        cor_done;
    wire        cor_fin;
    wire [15:0] cor_res;
    wire        ss_done;
    wire        ss_fin;
    wire [15:0] ss_res;

    oksac_meas #(
        .DONE_RST (1'b0),
        .RES_RST  (`OKSAC_RST_ZERO16),
        .RUN_CYC  (12'(`OKSAC_FEI_CYC))
    ) u_fei (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (fei_trig),
        .sample    (freq_error_sample),
        .done_ff   (fei_done),
        .finish_ff (fei_fin),
        .result_ff (fei_val)
    );

    oksac_meas #(
        .DONE_RST (1'b1),
        .RES_RST  (`OKSAC_RST_ZERO16),
        .RUN_CYC  (12'(`OKSAC_COR_CYC))
    ) u_cor (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (cor_start),
        .sample    (correction_sample),
        .done_ff   (cor_done),
        .finish_ff (cor_fin),
        .result_ff (cor_res)
    );

    oksac_meas #(
        .DONE_RST (1'b1),
        .RES_RST  (`OKSAC_RST_SSV),
        .RUN_CYC  (12'(`OKSAC_SS_CYC))
    ) u_ss (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (ss_trig),
        .sample    ({8'h00, signal_strength_sample}),
        .done_ff   (ss_done),
        .finish_ff (ss_fin),
        .result_ff (ss_res)
    );

    // Fresh result wins over a clear landing in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            correction_value_ff <= `OKSAC_RST_ZERO16;
            rx_mode_dly_ff      <= 1'b0;
        end else begin
            rx_mode_dly_ff <= rx_mode;
            if (cor_fin) begin
                correction_value_ff <= cor_res;
            end else if (cor_zero) begin
                correction_value_ff <= `OKSAC_RST_ZERO16;
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    wire [2:0] ev        = {ss_fin, cor_fin, fei_fin};
    wire [2:0] istat_clr = wr_istat ? w_data_ff[2:0] : 3'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_ff <= 3'h0;
            irq_ff   <= 1'b0;
        end else begin
            istat_ff <= (istat_ff & ~istat_clr) | ev;
            irq_ff   <= |(istat_ff & imask_ff);
        end
    end

    // ----------------------------------------
    // Slicer threshold
    // ----------------------------------------
    wire [8:0]         lvl9     = {1'b0, strength_level};
    wire               dec_tick = subchip_tick & (dec_cnt_ff == 8'h00);
    wire [8:0]         stp      = step_half(cfg_ff.step);
    wire [8:0]         thr_dec  = (thr_ff > stp) ? (thr_ff - stp) : 9'h000;
    wire [8:0]         thr_peak = (lvl9 > thr_ff) ? lvl9 : (dec_tick ? thr_dec : thr_ff);
    // Coefficients 00 and 01 share the slowest cutoff
    wire [3:0]         avg_sh   = (cfg_ff.filt == 2'h3) ? 4'h4 :
                                  (cfg_ff.filt == 2'h2) ? 4'h5 : 4'h8;
    wire signed [16:0] avg_diff = $signed({1'b0, strength_level, 8'h00}) - avg_ff;
    wire signed [16:0] nxt_avg  = subchip_tick ? (avg_ff + (avg_diff >>> avg_sh)) : avg_ff;
    wire [8:0]         nxt_thr  = (cfg_ff.thr_sel == OKSAC_THR_FIXED) ? {cfg_ff.fixed, 1'b0} :
                                  (cfg_ff.thr_sel == OKSAC_THR_PEAK)  ? thr_peak :
                                  (cfg_ff.thr_sel == OKSAC_THR_AVG)   ? {1'b0, nxt_avg[15:8]} :
                                  thr_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_ff         <= 9'h000;
            avg_ff         <= 17'sh00000;
            dec_cnt_ff     <= 8'h00;
            slicer_data_ff <= 1'b0;
        end else begin
            thr_ff         <= nxt_thr;
            avg_ff         <= nxt_avg;
            slicer_data_ff <= lvl9 >= thr_ff;
            if (subchip_tick) begin
                dec_cnt_ff <= (dec_cnt_ff == 8'h00) ? decay_len(cfg_ff.period) : dec_cnt_ff - 8'h01;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    wire [7:0] rd_ctl = {1'b0, fei_done, 1'b0, cor_done, autoclr_ff, rx_entry_on_ff, 2'h0};
    wire [7:0] rd_ssc = {6'h00, ss_done, 1'b0};
    wire [7:0] rd_mux =
        hit(s_axi_araddr, `OKSAC_IDX_PEAK)  ? {cfg_ff.thr_sel, cfg_ff.step, cfg_ff.period} :
        hit(s_axi_araddr, `OKSAC_IDX_AVG)   ? {cfg_ff.filt, 6'h00} :
        hit(s_axi_araddr, `OKSAC_IDX_FIX)   ? cfg_ff.fixed :
        hit(s_axi_araddr, `OKSAC_IDX_CTL)   ? rd_ctl :
        hit(s_axi_araddr, `OKSAC_IDX_CORH)  ? correction_value_ff[15:8] :
        hit(s_axi_araddr, `OKSAC_IDX_CORL)  ? correction_value_ff[7:0] :
        hit(s_axi_araddr, `OKSAC_IDX_FEIH)  ? fei_val[15:8] :
        hit(s_axi_araddr, `OKSAC_IDX_FEIL)  ? fei_val[7:0] :
        hit(s_axi_araddr, `OKSAC_IDX_SSC)   ? rd_ssc :
        hit(s_axi_araddr, `OKSAC_IDX_SSV)   ? ss_res[7:0] :
        hit(s_axi_araddr, `OKSAC_IDX_ISTAT) ? {5'h00, istat_ff} :
        hit(s_axi_araddr, `OKSAC_IDX_IMASK) ? {5'h00, imask_ff} : 8'h00;

    wire ar_take   = s_axi_arvalid & s_axi_arready;
    wire nxt_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~nxt_rvalid;
            s_axi_rvalid  <= nxt_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h000000, rd_mux};
                s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            end
        end
    end

endmodule

// ---- tb/oksac_asserts.sv ----
module oksac_asserts
    import oksac_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Receive side
    input wire logic        rx_mode,
    input wire logic [15:0] correction_value_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic       ar_t, wr_t, ctl_wr;
    logic [1:0] ctl_sh_ff;

    assign ar_t   = s_axi_arvalid && s_axi_arready;
    assign wr_t   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    assign ctl_wr = wr_t && s_axi_awaddr == 12'h078;

    // Autoclear and entry shadow, from writes taken in one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) ctl_sh_ff <= 2'h0;
        else if (ctl_wr) ctl_sh_ff <= s_axi_wdata[3:2];
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ctl_rd_zero_a: assert property (
        ar_t && s_axi_araddr == 12'h078 |=> (s_axi_rdata & 32'hffffffa3) == 32'h0)
        else $error("control trigger bits read nonzero");
    ssc_rd_zero_a: assert property (
        ar_t && s_axi_araddr == 12'h08c |=> (s_axi_rdata & 32'hfffffffd) == 32'h0)
        else $error("strength control unused bits nonzero");
    avg_rd_zero_a: assert property (
        ar_t && s_axi_araddr == 12'h070 |=> (s_axi_rdata & 32'hffffff3f) == 32'h0)
        else $error("average config unused bits nonzero");
    cor_rd_match_a: assert property (
        ar_t && s_axi_araddr == 12'h07c ##1 $stable(correction_value_ff)
        |-> s_axi_rdata == {24'h0, correction_value_ff[15:8]}) else $error("correction high byte mismatch");
    cor_clear_a: assert property (
        ctl_wr && s_axi_wdata[1] && rx_mode |-> ##[1:3] correction_value_ff == 16'h0)
        else $error("correction not cleared in receive");
    entry_clr_a: assert property (
        $rose(rx_mode) && ctl_sh_ff == 2'h3 |-> ##[1:2] correction_value_ff == 16'h0)
        else $error("autoclear on entry missing");
    entry_keep_a: assert property (
        $rose(rx_mode) && ctl_sh_ff != 2'h3 |=> $stable(correction_value_ff) [*2])
        else $error("correction changed on entry without autoclear");
    bad_rd_err_a: assert property (
        ar_t && s_axi_araddr == 12'h0fc |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    bad_wr_err_a: assert property (
        wr_t && s_axi_awaddr == 12'h0fc && !s_axi_bvalid |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("unmapped write not refused");
endmodule

bind oksac_top oksac_asserts i_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .rx_mode, .correction_value_ff
);

// ---- tb/tb_ook_slicer_afc_rssi_control.sv ----
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_ook_slicer_afc_rssi_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        rx_mode, subchip_tick, slicer_data_ff, irq_ff;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  strength_level, signal_strength_sample;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [15:0] freq_error_sample, correction_sample, correction_value_ff;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    int          fail_count = 0, checked = 0;

    oksac_top i_dut (.*);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic tmo(input bit over);
        if (over) begin
            fail_count++;
            stop_test();
        end
    endtask

    // Address and data offered together
    task automatic wr(input logic [7:0] idx, d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= {2'h0, idx, 2'h0};
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 2000);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n >= 2000);
    endtask

    task automatic rd(input logic [7:0] idx);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr  <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 2000);
        rd_d = s_axi_rdata;
        rsp  = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n >= 2000);
    endtask

    task automatic rdc(input logic [7:0] idx, e);
        rd(idx);
        `CHK({rsp, rd_d}, {2'h0, 24'h0, e})
    endtask

    task automatic poll(input logic [7:0] idx, input int b);
        int n = 0;
        do begin
            rd(idx);
            n++;
        end while (rd_d[b] !== 1'b1 && n < 1000);
        tmo(n >= 1000);
    endtask

    task automatic meas(input logic [7:0] idx, trig, input int b, input logic [7:0] busy);
        wr(idx, trig);
        rdc(idx, busy);
        poll(idx, b);
    endtask

    task automatic lvl(input logic [7:0] v, input logic e);
        @(posedge aclk);
        strength_level <= v;
        repeat (3) @(posedge aclk);
        `CHK(slicer_data_ff, e)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] rv [10] = '{8'h40, 8'h80, 8'h06, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'hff};
        for (int i = 0; i < 10; i++) begin
            rdc(8'h1b + 8'(i), rv[i]);
        end
        rd(8'h3f);
        `CHK({rsp, rd_d}, {2'h2, 32'h0})
        wr(8'h3f, 8'h55);
        `CHK(rsp, 2'h2)
        wr(8'h1c, 8'hff);
        rdc(8'h1c, 8'hc0);
        wr(8'h1f, 8'h55);
        rdc(8'h1f, 8'h00);
        wr(8'h24, 8'h00);
        rdc(8'h24, 8'hff);
        wr(8'h1b, 8'hff);
        rdc(8'h1b, 8'hff);
    endtask

    // One decay tick lowers the peak by one step
    task automatic t_peak(input logic [7:0] cfg, input logic [7:0] lo);
        wr(8'h1b, cfg);
        lvl(8'd100, 1'b1);
        lvl(lo, 1'b0);
        @(posedge aclk);
        subchip_tick <= 1'b1;
        @(posedge aclk);
        subchip_tick <= 1'b0;
        lvl(lo, 1'b1);
    endtask

    task automatic t_slicer();
        wr(8'h1b, 8'h00);
        wr(8'h1d, 8'h10);
        lvl(8'd31, 1'b0);
        lvl(8'd32, 1'b1);
        t_peak(8'h47, 8'd99);
        t_peak(8'h7f, 8'd89);
        wr(8'h1b, 8'h80);
        strength_level <= 8'd80;
        repeat (400) @(posedge aclk) subchip_tick <= ~subchip_tick;
        lvl(8'd78, 1'b0);
        lvl(8'd80, 1'b1);
    endtask

    task automatic t_meas();
        meas(8'h1e, 8'h20, 6, 8'h10);
        rdc(8'h21, 8'h81);
        rdc(8'h22, 8'h23);
        meas(8'h23, 8'h01, 1, 8'h00);
        rdc(8'h24, 8'h9a);
        meas(8'h1e, 8'h01, 4, 8'h40);
        rdc(8'h1f, 8'hfe);
        rdc(8'h20, 8'hdc);
        `CHK(correction_value_ff, 16'hfedc)
        rdc(8'h40, 8'h07);
        `CHK(irq_ff, 1'b0)
        wr(8'h41, 8'h02);
        rdc(8'h41, 8'h02);
        `CHK(irq_ff, 1'b1)
        wr(8'h40, 8'h02);
        rdc(8'h40, 8'h05);
        `CHK(irq_ff, 1'b0)
    endtask

    task automatic t_afc();
        wr(8'h1e, 8'h04);
        correction_sample <= 16'h1357;
        rx_mode           <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(correction_value_ff, 16'hfedc)
        rdc(8'h1e, 8'h44);
        poll(8'h1e, 4);
        `CHK(correction_value_ff, 16'h1357)
        wr(8'h1e, 8'h05);
        rdc(8'h1e, 8'h54);
        rx_mode <= 1'b0;
        wr(8'h1e, 8'h0c);
        correction_sample <= 16'h2468;
        rx_mode           <= 1'b1;
        repeat (3) @(posedge aclk);
        `CHK(correction_value_ff, 16'h0000)
        poll(8'h1e, 4);
        `CHK(correction_value_ff, 16'h2468)
        rx_mode <= 1'b0;
        wr(8'h1e, 8'h02);
        rdc(8'h1e, 8'h50);
        `CHK(correction_value_ff, 16'h2468)
        rx_mode <= 1'b1;
        rdc(8'h1e, 8'h50);
        wr(8'h1e, 8'h02);
        repeat (2) @(posedge aclk);
        `CHK(correction_value_ff, 16'h0000)
    endtask

    // ----------------------------------------
    // Main
    // ----------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {rx_mode, subchip_tick, strength_level, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb            = 4'hf;
        freq_error_sample      = 16'h8123;
        correction_sample      = 16'hfedc;
        signal_strength_sample = 8'h9a;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_slicer();
        t_meas();
        t_afc();
        stop_test();
    end
endmodule
